//--- hdl/sdp_pkg.sv
// constants for the synthesizer divider and phase lock logic
// assumes one 200 MHz clock and pin levels coded as sdp level codes

package sdp_pkg;

  // four-level pin codes, as delivered by the pad comparators
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_OPEN = 2'h1;
  localparam logic [1:0] LVL_VCC = 2'h2;
  localparam logic [1:0] LVL_HALF = 2'h3;

  localparam int CLK_MHZ = 200;
  localparam int LO_FACTOR = 2464;
  localparam int REF_W = 7;
  localparam int LO_W = 12;
  localparam int CMP_KHZ = 512;
  localparam int VCO_KHZ = 1261568;
  localparam int PHASE_WIN_NS = 250;
  // below the window counts, so round down
  localparam int PHASE_WIN_CYC = PHASE_WIN_NS * CLK_MHZ / 1000;
  localparam int LOCK_COUNT = 7;
  localparam int ERR_W = 8;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATE = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_PHASE_ERR = 8'h10;

  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // charge-pump current codes
  localparam logic [1:0] CP_OFF = 2'h0;
  localparam logic [1:0] CP_200UA = 2'h1;
  localparam logic [1:0] CP_300UA = 2'h2;

  function automatic logic [REF_W-1:0] sdp_ref_factor(
    input logic [1:0] a,
    input logic [1:0] b
  );
    logic [REF_W-1:0] f;
    f = 7'd64;
    case ({a, b})
      {LVL_GND, LVL_OPEN}: f = 7'd36;
      {LVL_GND, LVL_VCC}: f = 7'd33;
      {LVL_GND, LVL_GND}: f = 7'd48;
      {LVL_OPEN, LVL_OPEN}: f = 7'd65;
      {LVL_OPEN, LVL_VCC}: f = 7'd63;
      {LVL_OPEN, LVL_GND}: f = 7'd64;
      {LVL_VCC, LVL_OPEN}: f = 7'd35;
      {LVL_VCC, LVL_VCC}: f = 7'd32;
      {LVL_VCC, LVL_GND}: f = 7'd49;
      default: f = 7'd64;
    endcase
    return f;
  endfunction

endpackage

//--- hdl/sdp_divider.sv
// programmable edge-count divider with a factor latched at wrap
// assumes in_tick is a one-cycle pulse per input period, same clock

`timescale 1ns/1ps

module sdp_divider #(
  parameter int W = 7
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_tick,
  input wire logic [W-1:0] factor,
  output logic out_tick,
  output logic out_level
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] fac_q;
  logic wrap;

  assign wrap = in_tick && (cnt_q >= fac_q - W'(1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      fac_q <= '1;
    end else if (in_tick) begin
      if (wrap) begin
        cnt_q <= '0;
        fac_q <= factor;
      end else begin
        cnt_q <= cnt_q + W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_tick <= 1'b0;
      out_level <= 1'b0;
    end else begin
      out_tick <= wrap;
      out_level <= (cnt_q < (fac_q >> 1));
    end
  end

endmodule

//--- hdl/sdp_synth.sv
// synthesizer dividers, tri-state phase detector, lock detector,
// test multiplexer and an axi4-lite register slave
// assumes ref_osc_input and lo_osc_input are synchronous to aclk

`timescale 1ns/1ps

// How it works
// - oscillator divided by fixed 2464
// - nine reference factors from two straps
// - strap pair decodes to fixed factor table
// - loop drives vco to 2464 times ratio
// - standard setting compares at 512 kHz
// - locked vco 1261.568 MHz, divider 512 kHz
// - tri-state detector sources, sinks or idles
// - low 200 uA, high 300 uA, lock valid
// - half-supply control turns pump off
// - open control grounds amp and pump
// - lock after seven comparisons under 250 ns
// - lock releases open-collector indicator high
// - half or open control disables lock detect
// - open control monitors reference divider
// - half monitors oscillator divider, else nothing
module sdp_synth
  import sdp_pkg::*;
#(
  parameter int LO_DIV = LO_FACTOR,
  parameter int LOCK_N = LOCK_COUNT,
  parameter int WIN_CYC = PHASE_WIN_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ref_osc_input,
  input wire logic lo_osc_input,
  input wire logic [1:0] ref_div_select_a,
  input wire logic [1:0] ref_div_select_b,
  input wire logic [1:0] synth_control_select,
  output logic charge_pump_source,
  output logic charge_pump_sink,
  output logic [1:0] charge_pump_current,
  output logic charge_pump_out_ground,
  output logic loop_amp_input_ground,
  input wire logic lock_indicator_in,
  output logic lock_indicator_out,
  output logic lock_indicator_oe,
  output logic test_monitor_out,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // counters are sized for these ranges; refuse anything wider
  generate
    if (LO_DIV < 2 || LO_DIV > 4095 || LOCK_N < 1 || LOCK_N > 15 ||
        WIN_CYC < 1 || WIN_CYC > 254) begin : g_bad_param
      $error("sdp_synth: parameter out of range");
    end
  endgenerate
  // input edge detection
  logic ref_prev_q, lo_prev_q;
  logic ref_in_tick, lo_in_tick;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_prev_q <= 1'b0;
      lo_prev_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_osc_input;
      lo_prev_q <= lo_osc_input;
    end
  end

  assign ref_in_tick = ref_osc_input && !ref_prev_q;
  assign lo_in_tick = lo_osc_input && !lo_prev_q;
  // dividers; factor is picked up only at wrap
  logic [REF_W-1:0] ref_factor;
  logic ref_tick, ref_level, lo_tick, lo_level;
  // straps may be stepped to n+1 to move spurs
  assign ref_factor = sdp_ref_factor(ref_div_select_a,
                                     ref_div_select_b);

  sdp_divider #(
    .W(REF_W)
  ) u_ref_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_tick(ref_in_tick),
    .factor(ref_factor),
    .out_tick(ref_tick),
    .out_level(ref_level)
  );

  sdp_divider #(
    .W(LO_W)
  ) u_lo_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_tick(lo_in_tick),
    .factor(LO_W'(LO_DIV)),
    .out_tick(lo_tick),
    .out_level(lo_level)
  );

  // control pin decode
  logic ctl_pump_on, ctl_open, ctl_lock_on;
  logic ctrl_pump_en_q, ctrl_lock_en_q;
  assign ctl_open = (synth_control_select == LVL_OPEN);
  assign ctl_pump_on = ((synth_control_select == LVL_GND) ||
                        (synth_control_select == LVL_VCC))
                       && ctrl_pump_en_q;
  assign ctl_lock_on = ((synth_control_select == LVL_GND) ||
                        (synth_control_select == LVL_VCC))
                       && ctrl_lock_en_q;
  // tri-state phase detector
  logic up_q, dn_q, up_n, dn_n, cmp_done;
  logic [ERR_W-1:0] err_q, last_err_q;
  assign up_n = up_q || ref_tick;
  assign dn_n = dn_q || lo_tick;
  assign cmp_done = up_n && dn_n;

  // reference leading pumps up, oscillator leading pumps down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end else begin
      up_q <= up_n && !dn_n;
      dn_q <= dn_n && !up_n;
    end
  end

  // cycles between the two edges, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_q <= '0;
      last_err_q <= '0;
    end else if (cmp_done) begin
      err_q <= '0;
      last_err_q <= err_q;
    end else if (up_n || dn_n) begin
      if (err_q != '1) begin
        err_q <= err_q + ERR_W'(1);
      end
    end
  end
  // charge pump and loop filter controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      charge_pump_source <= 1'b0;
      charge_pump_sink <= 1'b0;
      charge_pump_current <= CP_OFF;
      charge_pump_out_ground <= 1'b0;
      loop_amp_input_ground <= 1'b0;
    end else begin
      charge_pump_source <= ctl_pump_on && up_n && !dn_n;
      charge_pump_sink <= ctl_pump_on && dn_n && !up_n;
      if (!ctl_pump_on) begin
        charge_pump_current <= CP_OFF;
      end else if (synth_control_select == LVL_VCC) begin
        charge_pump_current <= CP_300UA;
      end else begin
        charge_pump_current <= CP_200UA;
      end
      charge_pump_out_ground <= ctl_open;
      loop_amp_input_ground <= ctl_open;
    end
  end

  // lock detector
  logic [3:0] good_q;
  logic lock_q, cmp_good;
  assign cmp_good = (err_q < ERR_W'(WIN_CYC));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      good_q <= '0;
      lock_q <= 1'b0;
    end else if (!ctl_lock_on) begin
      good_q <= '0;
      lock_q <= 1'b0;
    end else if (cmp_done) begin
      if (!cmp_good) begin
        good_q <= '0;
        lock_q <= 1'b0;
      end else if (good_q >= 4'(LOCK_N - 1)) begin
        good_q <= 4'(LOCK_N);
        lock_q <= 1'b1;
      end else begin
        good_q <= good_q + 4'd1;
      end
    end
  end

  // open collector: pulls low while unlocked, released when locked;
  // while disabled it pulls low, a fixed answer for an undefined pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_indicator_out <= 1'b0;
      lock_indicator_oe <= 1'b1;
    end else begin
      lock_indicator_out <= 1'b0;
      lock_indicator_oe <= !lock_q;
    end
  end
  // test monitor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_monitor_out <= 1'b0;
    end else begin
      case (synth_control_select)
        LVL_OPEN: test_monitor_out <= ref_level;
        LVL_HALF: test_monitor_out <= lo_level;
        default: test_monitor_out <= 1'b0;
      endcase
    end
  end

  // interrupt events: bit 0 lock gained, bit 1 lock lost
  logic lock_prev_q, wr_fire;
  logic [1:0] irq_ev, irq_stat_q, irq_mask_q, w1c;
  logic [7:0] wr_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0] wr_strb_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_prev_q <= 1'b0;
    end else begin
      lock_prev_q <= lock_q;
    end
  end

  assign irq_ev = {lock_prev_q && !lock_q, lock_q && !lock_prev_q};
  assign w1c = (wr_fire && wr_addr_q == OFS_IRQ_STAT && wr_strb_q[0])
               ? wr_data_q[1:0] : 2'h0;

  // a new event beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~w1c) | irq_ev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // axi4-lite write channel
  logic aw_got_q, w_got_q;
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      wr_addr_q <= '0;
      wr_data_q <= '0;
      wr_strb_q <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (wr_addr_q)
          OFS_CTRL, OFS_IRQ_STAT, OFS_IRQ_MASK:
            s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // writable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_pump_en_q <= CTRL_RESET[0];
      ctrl_lock_en_q <= CTRL_RESET[1];
      irq_mask_q <= MASK_RESET;
    end else if (wr_fire && wr_strb_q[0]) begin
      if (wr_addr_q == OFS_CTRL) begin
        ctrl_pump_en_q <= wr_data_q[0];
        ctrl_lock_en_q <= wr_data_q[1];
      end
      if (wr_addr_q == OFS_IRQ_MASK) begin
        irq_mask_q <= wr_data_q[1:0];
      end
    end
  end

  // axi4-lite read channel, answer one cycle after address
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      OFS_CTRL: rd_mux = {30'h0, ctrl_lock_en_q, ctrl_pump_en_q};
      OFS_STATE: rd_mux = {9'h0, ref_factor,
                           4'h0, good_q,
                           2'h0, synth_control_select,
                           2'h0, lock_indicator_in, lock_q};
      OFS_IRQ_STAT: rd_mux = {30'h0, irq_stat_q};
      OFS_IRQ_MASK: rd_mux = {30'h0, irq_mask_q};
      OFS_PHASE_ERR: rd_mux = {24'h0, last_err_q};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

//--- tb/sdp_synth_chk.sv
// checker on the pump, lock pin and test outputs of sdp_synth
// assumes a bind to sdp_synth and registered outputs
`timescale 1ns/1ps
module sdp_synth_chk
  import sdp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] synth_control_select,
  input wire logic charge_pump_source,
  input wire logic charge_pump_sink,
  input wire logic [1:0] charge_pump_current,
  input wire logic charge_pump_out_ground,
  input wire logic loop_amp_input_ground,
  input wire logic lock_indicator_out,
  input wire logic lock_indicator_oe,
  input wire logic test_monitor_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic [1:0] sel = synth_control_select;
  wire logic dis = sel == LVL_HALF || sel == LVL_OPEN;
  wire logic quiet = sel == LVL_GND || sel == LVL_VCC;
  property p_half_off;
    (sel == LVL_HALF) [*3] |-> charge_pump_current == CP_OFF &&
      !charge_pump_source && !charge_pump_sink;
  endproperty
  a_half_off: assert property (p_half_off)
    else $error("pump active at half level");
  property p_open_gnd;
    (sel == LVL_OPEN) [*3] |-> charge_pump_out_ground &&
      loop_amp_input_ground;
  endproperty
  a_open_gnd: assert property (p_open_gnd)
    else $error("grounds not applied while open");
  property p_cur_hi;
    charge_pump_current == CP_300UA |->
      $past(sel) == LVL_VCC || $past(sel, 2) == LVL_VCC;
  endproperty
  a_cur_hi: assert property (p_cur_hi)
    else $error("high current without high level");
  property p_cur_lo;
    charge_pump_current == CP_200UA |->
      $past(sel) == LVL_GND || $past(sel, 2) == LVL_GND;
  endproperty
  a_cur_lo: assert property (p_cur_lo)
    else $error("low current without low level");
  property p_tri;
    !(charge_pump_source && charge_pump_sink);
  endproperty
  a_tri: assert property (p_tri)
    else $error("pump sources and sinks at once");
  property p_lock_off;
    dis [*3] |-> lock_indicator_oe;
  endproperty
  a_lock_off: assert property (p_lock_off)
    else $error("lock shown while detector off");
  property p_oc;
    lock_indicator_out == 1'b0;
  endproperty
  a_oc: assert property (p_oc)
    else $error("lock pin driven high");
  property p_gain;
    $fell(lock_indicator_oe) |-> $past(quiet) && $past(quiet, 2);
  endproperty
  a_gain: assert property (p_gain)
    else $error("lock gained with detector off");
  property p_tst_quiet;
    quiet [*2] |-> test_monitor_out == 1'b0;
  endproperty
  a_tst_quiet: assert property (p_tst_quiet)
    else $error("test output active in normal mode");
  c_lock: cover property ($fell(lock_indicator_oe));
  c_mon: cover property (sel == LVL_OPEN && $changed(test_monitor_out));
  c_hi: cover property (charge_pump_current == CP_300UA);
endmodule
bind sdp_synth sdp_synth_chk sdp_synth_chk_inst (
  .aclk(aclk),
  .aresetn(aresetn),
  .synth_control_select(synth_control_select),
  .charge_pump_source(charge_pump_source),
  .charge_pump_sink(charge_pump_sink),
  .charge_pump_current(charge_pump_current),
  .charge_pump_out_ground(charge_pump_out_ground),
  .loop_amp_input_ground(loop_amp_input_ground),
  .lock_indicator_out(lock_indicator_out),
  .lock_indicator_oe(lock_indicator_oe),
  .test_monitor_out(test_monitor_out)
);

//--- tb/sdp_board_model.sv
// board side: crystal, loop filter with oscillator, lock pull-up
// assumes pump outputs are levels on aclk
`timescale 1ns/1ps
module sdp_board_model (
  input wire logic aclk,
  input wire logic charge_pump_source,
  input wire logic charge_pump_sink,
  input wire logic lock_indicator_out,
  input wire logic lock_indicator_oe,
  output logic ref_osc_input,
  output logic lo_osc_input,
  output logic lock_indicator_in
);
  int lo_cnt = 0;
  logic ref_q = 1'b0;
  logic lo_q = 1'b0;
  assign ref_osc_input = ref_q;
  assign lo_osc_input = lo_q;
  always @(posedge aclk) ref_q <= ~ref_q;
  // pump steers the oscillator half period, so phase converges
  always @(posedge aclk) begin
    if (lo_cnt <= 0) begin
      lo_q <= ~lo_q;
      lo_cnt <= charge_pump_source ? 2 : charge_pump_sink ? 4 : 3;
    end else begin
      lo_cnt <= lo_cnt - 1;
    end
  end
  // open collector: the pull-up wins only when released
  assign lock_indicator_in = lock_indicator_oe ? lock_indicator_out : 1'b1;
endmodule

//--- tb/tb_sdp_synth.sv
// self-checking bench for sdp_synth over axi4-lite
// assumes the board model closes the loop on the pump outputs
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; \
  if ((got) !== (ex)) begin err_total++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module tb_sdp_synth;
  import sdp_pkg::*;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [1:0] sel_a = LVL_VCC, sel_b = LVL_VCC, ctl = LVL_GND;
  logic src, snk, ogr, agr, lk_out, lk_oe, lk_in, tmon, irq, ref_o, lo_o;
  logic [1:0] cur, bresp, rresp, eb;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [65:0] e;
  logic [1:0] wq[$];
  logic [65:0] rq[$];
  int err_total = 0, tests_run = 0, cyc = 0, n;
  int fac[9] = '{36, 33, 48, 65, 63, 64, 35, 32, 49};
  always #2.5 aclk = ~aclk;
  sdp_synth #(.LO_DIV(8)) sdp_synth_inst (
    .aclk(aclk), .aresetn(aresetn), .ref_osc_input(ref_o),
    .lo_osc_input(lo_o), .ref_div_select_a(sel_a),
    .ref_div_select_b(sel_b), .synth_control_select(ctl),
    .charge_pump_source(src), .charge_pump_sink(snk),
    .charge_pump_current(cur), .charge_pump_out_ground(ogr),
    .loop_amp_input_ground(agr), .lock_indicator_in(lk_in),
    .lock_indicator_out(lk_out), .lock_indicator_oe(lk_oe),
    .test_monitor_out(tmon), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  sdp_board_model sdp_board_model_inst (
    .aclk(aclk), .charge_pump_source(src), .charge_pump_sink(snk),
    .lock_indicator_out(lk_out), .lock_indicator_oe(lk_oe),
    .ref_osc_input(ref_o), .lo_osc_input(lo_o),
    .lock_indicator_in(lk_in));
  task automatic stop_test();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] r);
    wq.push_back(r);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    // let one edge pass so a following call never re-raises in this step
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v,
                    input logic [31:0] m, input logic [1:0] r);
    rq.push_back({m, r, v});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic tk(input int c);
    repeat (c) @(posedge aclk);
  endtask
  task automatic tog(output int t);
    logic p;
    t = 0;
    p = tmon;
    repeat (300) begin
      @(posedge aclk);
      if (tmon !== p) t++;
      p = tmon;
    end
  endtask
  // results are judged where they appear, against the oldest note
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready) begin
      eb = wq.pop_front();
      `CHK("bresp", eb, bresp)
    end
    if (rvalid === 1'b1 && rready) begin
      e = rq.pop_front();
      `CHK("rresp", e[33:32], rresp)
      `CHK("rdata", e[31:0], rdata & e[65:34])
    end
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(6376));
    tk(16);
    aresetn <= 1'b1;
    tk(1);
    rd(OFS_CTRL, 32'h0000_0003, ALL, RESP_OKAY);
    rd(OFS_IRQ_MASK, 32'h0000_0000, ALL, RESP_OKAY);
    d = $urandom;
    wr(OFS_IRQ_MASK, d, RESP_OKAY);
    rd(OFS_IRQ_MASK, {30'h0, d[1:0]}, ALL, RESP_OKAY);
    wr(8'h20, d, RESP_SLVERR);
    rd(8'h20, 32'h0000_0000, 32'h0000_0000, RESP_SLVERR);
    wr(OFS_STATE, d, RESP_SLVERR);
    for (int i = 0; i < 9; i++) begin
      sel_a <= 2'(i / 3);
      sel_b <= 2'((i + 1) % 3);
      tk(2);
      rd(OFS_STATE, 32'(fac[i]) << 16, 32'h007f_0000, RESP_OKAY);
    end
    sel_a <= LVL_VCC;
    sel_b <= LVL_VCC;
    wr(OFS_IRQ_MASK, 32'h0000_0003, RESP_OKAY);
    wait (irq === 1'b1);
    tk(1);
    rd(OFS_STATE, 32'h0000_0003, 32'h0000_0003, RESP_OKAY);
    rd(OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0003, RESP_OKAY);
    wr(OFS_IRQ_STAT, 32'h0000_0001, RESP_OKAY);
    tk(3);
    `CHK("irq", 1'b0, irq)
    ctl <= LVL_VCC;
    tk(4);
    `CHK("current", CP_300UA, cur)
    rd(OFS_STATE, 32'h0000_0001, 32'h0000_0001, RESP_OKAY);
    ctl <= LVL_HALF;
    tk(6);
    `CHK("current", CP_OFF, cur)
    `CHK("irq", 1'b1, irq)
    tog(n);
    // lo factor 8 on an 8-cycle oscillator: level flips every 32 cycles
    `CHK("lo monitor", 1'b1, n >= 8 && n <= 11)
    ctl <= LVL_OPEN;
    sel_a <= LVL_OPEN;
    tk(4);
    `CHK("grounds", 2'b11, {ogr, agr})
    rd(OFS_STATE, 32'h003f_0000, 32'h007f_0000, RESP_OKAY);
    sel_b <= LVL_GND; // board steps 63 up to 64
    tk(200);
    rd(OFS_STATE, 32'h0040_0000, 32'h007f_0000, RESP_OKAY);
    tog(n);
    // factor 64 on a 2-cycle reference: level flips every 64 cycles
    `CHK("ref monitor", 1'b1, n >= 3 && n <= 6)
    stop_test();
  end
endmodule
